// ===== logic/command_and_interrupt_regs.sv
// command register, interrupt enables and requests, interrupt pin drive
// assumes events arrive synchronous to i_clk_sys from the command engine,
// fifo, receiver and timer; the pin wire is resolved outside
`timescale 1ns/1ps

// Functional notes
// - register zero reserved, reads zero
// - bit five switches receiver analog off
// - bit four sleeps; reads one while waking
// - sleep write ignored during restart command
// - code write starts; read shows running
// - enable bit seven inverts pin level
// - default invert plus open-drain floats pin
// - aux bit seven selects push-pull drive
// - main enables gate seven main requests
// - aux enables gate card, checksum requests
// - mark-and-set write sets or clears
// - requests set by hardware, cleared by software
// - transmit done sets bit six
// - receive end sets bit five, data option
// - command end or unknown sets idle
// - host idle write sets no idle request
// - watermark requests latch rising flags
// - any error flag sets error request
// - timer reaching zero sets timer request
// - card input edge sets aux request
// - checksum done sets aux request
module command_and_interrupt_regs (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [cmd_irq_pkg::ADDR_W-1:0] i_addr, // register address
  input wire logic [cmd_irq_pkg::DATA_W-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [cmd_irq_pkg::DATA_W-1:0] o_rdata, // read data, next cycle
  input wire cmd_irq_pkg::event_in_t i_evt, // event inputs
  output cmd_irq_pkg::core_ctrl_t o_ctrl, // controls to the core
  input wire logic i_irq_in, // interrupt pin level seen
  output logic o_irq_out, // interrupt pin drive value
  output logic o_irq_oe_n // interrupt pin enable, low drives
);

  // reset lets go on a clock edge so every flop leaves it in the same cycle
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  logic wr_cmd;
  logic wr_men;
  logic wr_aen;
  logic wr_mreq;
  logic wr_areq;

  always_comb begin
    // unmapped offsets match nothing, so stray writes are dropped
    wr_cmd = i_wr && (i_addr == cmd_irq_pkg::OFS_COMMAND);
    wr_men = i_wr && (i_addr == cmd_irq_pkg::OFS_MAIN_EN);
    wr_aen = i_wr && (i_addr == cmd_irq_pkg::OFS_AUX_EN);
    wr_mreq = i_wr && (i_addr == cmd_irq_pkg::OFS_MAIN_REQ);
    wr_areq = i_wr && (i_addr == cmd_irq_pkg::OFS_AUX_REQ);
  end

  // command register state
  logic rcv_off_q;
  logic rcv_off_d;
  logic [3:0] code_q;
  logic [3:0] code_d;
  logic start_q;
  logic start_d;
  logic idle_evt;
  logic [3:0] wcode;
  cmd_irq_pkg::pwr_state_t pwr_q;
  cmd_irq_pkg::pwr_state_t pwr_d;
  logic sleep_bit;
  logic sleep_wr;

  always_comb begin
    wcode = i_wdata[cmd_irq_pkg::CMD_CODE_HI:0];
    rcv_off_d = rcv_off_q;
    code_d = code_q;
    start_d = 1'b0;
    idle_evt = 1'b0;
    // every command write rewrites the receiver bit with the rest
    // receiver switch
    if (wr_cmd) begin
      rcv_off_d = i_wdata[cmd_irq_pkg::CMD_RCV_OFF];
    end
    // a host write outranks a finish in the same cycle; the finish is dropped
    if (wr_cmd) begin
      // every code is known for now; the revert path covers retired codes
      // start the written code
      if (cmd_irq_pkg::CODE_KNOWN[wcode]) begin
        code_d = wcode;
        start_d = (wcode != cmd_irq_pkg::CODE_IDLE);
      end else begin
        code_d = cmd_irq_pkg::CODE_IDLE;
        idle_evt = 1'b1;
      end
    end else if (i_evt.command_finished &&
                 code_q != cmd_irq_pkg::CODE_IDLE) begin
      code_d = cmd_irq_pkg::CODE_IDLE;
      idle_evt = 1'b1;
    end
  end

  always_comb begin
    pwr_d = pwr_q;
    sleep_wr = wr_cmd && i_wdata[cmd_irq_pkg::CMD_SLEEP] &&
        (code_q != cmd_irq_pkg::CODE_RESTART);
    case (pwr_q)
      cmd_irq_pkg::PWR_AWAKE: begin
        if (sleep_wr) begin
          pwr_d = cmd_irq_pkg::PWR_ASLEEP;
        end
      end
      cmd_irq_pkg::PWR_ASLEEP: begin
        if (wr_cmd && !i_wdata[cmd_irq_pkg::CMD_SLEEP]) begin
          pwr_d = cmd_irq_pkg::PWR_WAKING;
        end
      end
      cmd_irq_pkg::PWR_WAKING: begin
        // a fresh sleep write beats wake-up
        if (sleep_wr) begin
          pwr_d = cmd_irq_pkg::PWR_ASLEEP;
        end else if (i_evt.wake_ready) begin
          pwr_d = cmd_irq_pkg::PWR_AWAKE;
        end
      end
      // an illegal one-hot code falls back to awake
      default: begin
        pwr_d = cmd_irq_pkg::PWR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rcv_off_q <= cmd_irq_pkg::RST_COMMAND[cmd_irq_pkg::CMD_RCV_OFF];
      code_q <= cmd_irq_pkg::RST_COMMAND[cmd_irq_pkg::CMD_CODE_HI:0];
      start_q <= 1'b0;
      pwr_q <= cmd_irq_pkg::PWR_AWAKE;
    end else begin
      rcv_off_q <= rcv_off_d;
      code_q <= code_d;
      start_q <= start_d;
      pwr_q <= pwr_d;
    end
  end

  // waking still reads as sleeping so software polls until the core is up
  // reads one until ready
  always_comb begin
    sleep_bit = (pwr_q != cmd_irq_pkg::PWR_AWAKE);
  end

  // event edge tracking
  logic hi_prev_q;
  logic lo_prev_q;
  logic card_prev_q;
  // the first live edge only loads the history, so a card input that idles
  // high does not fake an edge as reset lets go; a real edge then is lost
  logic armed_q;
  logic [6:0] main_evt;
  logic [7:0] aux_evt;

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hi_prev_q <= 1'b0;
      lo_prev_q <= 1'b0;
      card_prev_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      hi_prev_q <= i_evt.fifo_high_watermark;
      lo_prev_q <= i_evt.fifo_low_watermark;
      card_prev_q <= i_evt.card_side_serial_input;
      armed_q <= 1'b1;
    end
  end

  always_comb begin
    main_evt = '0;
    aux_evt = '0;
    main_evt[cmd_irq_pkg::REQ_TX] = i_evt.tx_last_bit_sent;
    main_evt[cmd_irq_pkg::REQ_RX] = i_evt.rx_stream_end &&
        (!i_evt.rx_require_data || i_evt.fifo_has_data);
    main_evt[cmd_irq_pkg::REQ_IDLE] = idle_evt;
    // a watermark already high as reset lets go counts as newly set
    // latch rising watermarks
    main_evt[cmd_irq_pkg::REQ_HI] = i_evt.fifo_high_watermark && !hi_prev_q;
    main_evt[cmd_irq_pkg::REQ_LO] = i_evt.fifo_low_watermark && !lo_prev_q;
    main_evt[cmd_irq_pkg::REQ_ERR] = |i_evt.error_flag_register;
    main_evt[cmd_irq_pkg::REQ_TIMER] = i_evt.timer_count_zero;
    aux_evt[cmd_irq_pkg::AUX_CARD] = armed_q &&
        (i_evt.card_side_serial_input ^ card_prev_q);
    aux_evt[cmd_irq_pkg::AUX_CSUM] = i_evt.checksum_data_done &&
        (code_q == cmd_irq_pkg::CODE_CHECKSUM);
  end

  // enables and requests
  logic [7:0] men_q;
  logic [7:0] men_d;
  logic [7:0] aen_q;
  logic [7:0] aen_d;
  logic [6:0] mreq_q;
  logic [6:0] mreq_d;
  logic [7:0] areq_q;
  logic [7:0] areq_d;

  always_comb begin
    // every main enable bit is plain storage, the invert bit included
    men_d = wr_men ? i_wdata : men_q;
    // reserved aux enable bits stay zero
    aen_d = aen_q;
    if (wr_aen) begin
      aen_d = i_wdata & (cmd_irq_pkg::AUX_IMPL |
          (8'h01 << cmd_irq_pkg::EN_DRIVE));
    end
    mreq_d = mreq_q;
    areq_d = areq_q;
    if (wr_mreq) begin
      if (i_wdata[cmd_irq_pkg::MARK_SET]) begin
        mreq_d = mreq_q | i_wdata[cmd_irq_pkg::REQ_TX:0];
      end else begin
        mreq_d = mreq_q & ~i_wdata[cmd_irq_pkg::REQ_TX:0];
      end
    end
    // only the card and checksum bits exist in the aux request register
    if (wr_areq) begin
      if (i_wdata[cmd_irq_pkg::MARK_SET]) begin
        areq_d = areq_q | (i_wdata & cmd_irq_pkg::AUX_IMPL);
      end else begin
        areq_d = areq_q & ~(i_wdata & cmd_irq_pkg::AUX_IMPL);
      end
    end
    // an event in the cycle of a clear must not be lost, so it is ORed last
    // hardware only sets; set wins
    mreq_d = (mreq_d | main_evt) & cmd_irq_pkg::MAIN_REQ_MASK;
    areq_d = (areq_d | aux_evt) & cmd_irq_pkg::AUX_IMPL;
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      men_q <= cmd_irq_pkg::RST_MAIN_EN;
      aen_q <= cmd_irq_pkg::RST_AUX_EN;
      mreq_q <= cmd_irq_pkg::RST_MAIN_REQ[6:0];
      areq_q <= cmd_irq_pkg::RST_AUX_REQ;
    end else begin
      men_q <= men_d;
      aen_q <= aen_d;
      mreq_q <= mreq_d;
      areq_q <= areq_d;
    end
  end

  // interrupt pin
  logic irq_flag;
  logic main_hit;
  logic aux_hit;
  logic irq_level;
  logic irq_out_d;
  logic irq_oe_n_d;
  logic irq_out_q;
  logic irq_oe_n_q;

  always_comb begin
    main_hit = |(mreq_q & men_q[cmd_irq_pkg::REQ_TX:0]);
    aux_hit = |(areq_q & aen_q & cmd_irq_pkg::AUX_IMPL);
    irq_flag = main_hit || aux_hit;
    irq_level = men_q[cmd_irq_pkg::EN_INVERT] ? !irq_flag : irq_flag;
    if (aen_q[cmd_irq_pkg::EN_DRIVE]) begin
      irq_out_d = irq_level;
      irq_oe_n_d = 1'b0;
    end else begin
      irq_out_d = 1'b0;
      irq_oe_n_d = irq_level;
    end
  end

  // both pin outputs come from flops so value and enable switch together
  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_out_q <= 1'b0;
      irq_oe_n_q <= 1'b1;
    end else begin
      irq_out_q <= irq_out_d;
      irq_oe_n_q <= irq_oe_n_d;
    end
  end

  // read port
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    // idle cycles read zero so a stale value never looks like an answer
    rdata_d = cmd_irq_pkg::ZERO8;
    if (i_rd) begin
      case (i_addr)
        cmd_irq_pkg::OFS_RESERVED: rdata_d = cmd_irq_pkg::RST_RESERVED;
        cmd_irq_pkg::OFS_COMMAND: begin
          rdata_d[cmd_irq_pkg::CMD_RCV_OFF] = rcv_off_q;
          rdata_d[cmd_irq_pkg::CMD_SLEEP] = sleep_bit;
          rdata_d[cmd_irq_pkg::CMD_CODE_HI:0] = code_q;
        end
        cmd_irq_pkg::OFS_MAIN_EN: rdata_d = men_q;
        cmd_irq_pkg::OFS_AUX_EN: rdata_d = aen_q;
        cmd_irq_pkg::OFS_MAIN_REQ: rdata_d = {1'b0, mreq_q};
        cmd_irq_pkg::OFS_AUX_REQ: rdata_d = areq_q;
        default: rdata_d = cmd_irq_pkg::ZERO8;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q <= cmd_irq_pkg::ZERO8;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // pin readback is not needed; the flag drives the pin through the output flops
  logic unused_pin;

  always_comb begin
    unused_pin = i_irq_in;
  end

  always_comb begin
    o_rdata = rdata_q;
    o_irq_out = irq_out_q;
    o_irq_oe_n = irq_oe_n_q;
    o_ctrl.receiver_analog_off = rcv_off_q;
    // the core sees sleep only while asleep, not during wake-up
    o_ctrl.soft_sleep_request = (pwr_q == cmd_irq_pkg::PWR_ASLEEP);
    o_ctrl.command_code = code_q;
    // start pulses once; the engine keeps the code from command_code
    o_ctrl.command_start = start_q;
  end

endmodule // command_and_interrupt_regs

// ===== pkg/cmd_irq_pkg.sv
// constants and carriers for the command and interrupt register group
// assumes one system clock and an 8-bit register port
package cmd_irq_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] OFS_RESERVED = 6'h00;
  localparam logic [5:0] OFS_COMMAND = 6'h01;
  localparam logic [5:0] OFS_MAIN_EN = 6'h02;
  localparam logic [5:0] OFS_AUX_EN = 6'h03;
  localparam logic [5:0] OFS_MAIN_REQ = 6'h04;
  localparam logic [5:0] OFS_AUX_REQ = 6'h05;
  localparam logic [7:0] RST_RESERVED = 8'h00;
  localparam logic [7:0] RST_COMMAND = 8'h20;
  localparam logic [7:0] RST_MAIN_EN = 8'h80;
  localparam logic [7:0] RST_AUX_EN = 8'h00;
  localparam logic [7:0] RST_MAIN_REQ = 8'h14;
  localparam logic [7:0] RST_AUX_REQ = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  // command register fields
  localparam int CMD_RCV_OFF = 5;
  localparam int CMD_SLEEP = 4;
  localparam int CMD_CODE_HI = 3;
  // enable and request field positions
  localparam int MARK_SET = 7;
  localparam int EN_INVERT = 7;
  localparam int EN_DRIVE = 7;
  localparam int REQ_TX = 6;
  localparam int REQ_RX = 5;
  localparam int REQ_IDLE = 4;
  localparam int REQ_HI = 3;
  localparam int REQ_LO = 2;
  localparam int REQ_ERR = 1;
  localparam int REQ_TIMER = 0;
  localparam int AUX_CARD = 4;
  localparam int AUX_CSUM = 2;
  localparam logic [7:0] AUX_IMPL = 8'h14;
  localparam logic [6:0] MAIN_REQ_MASK = 7'h7f;
  // command codes
  localparam logic [3:0] CODE_IDLE = 4'h0;
  localparam logic [3:0] CODE_CHECKSUM = 4'h3;
  localparam logic [3:0] CODE_RESTART = 4'hf;
  localparam logic [15:0] CODE_KNOWN = 16'hffff;

  typedef enum logic [2:0] {
    PWR_AWAKE = 3'b001,
    PWR_ASLEEP = 3'b010,
    PWR_WAKING = 3'b100
  } pwr_state_t;

  typedef struct packed {
    logic tx_last_bit_sent;
    logic rx_stream_end;
    logic fifo_has_data;
    logic rx_require_data;
    logic fifo_high_watermark;
    logic fifo_low_watermark;
    logic [7:0] error_flag_register;
    logic timer_count_zero;
    logic card_side_serial_input;
    logic checksum_data_done;
    logic command_finished;
    logic wake_ready;
  } event_in_t;

  typedef struct packed {
    logic receiver_analog_off;
    logic soft_sleep_request;
    logic [3:0] command_code;
    logic command_start;
  } core_ctrl_t;
endpackage

// ===== sim/irq_line_model.sv
// host side of the interrupt wire: a pull-up resistor and the device driver
// assumes the device drives the wire only while its enable is low
`timescale 1ns/1ps
module irq_line_model (
  input wire logic i_irq_out, // device drive value
  input wire logic i_irq_oe_n, // device enable, low drives
  output logic o_line // resolved wire level
);
  assign o_line = i_irq_oe_n ? 1'b1 : i_irq_out;
endmodule // irq_line_model

// ===== sim/cmd_irq_monitor.sv
// checker on the register port and core controls of the register group
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module cmd_irq_monitor (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [cmd_irq_pkg::ADDR_W-1:0] i_addr, // register address
  input wire logic [cmd_irq_pkg::DATA_W-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [cmd_irq_pkg::DATA_W-1:0] o_rdata, // read data
  input wire cmd_irq_pkg::event_in_t i_evt, // event inputs
  input wire cmd_irq_pkg::core_ctrl_t o_ctrl, // controls to the core
  input wire logic i_irq_in, // pin level seen
  input wire logic o_irq_out, // pin drive value
  input wire logic o_irq_oe_n // pin enable
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence cmd_wr_s;
    i_wr && i_addr == cmd_irq_pkg::OFS_COMMAND;
  endsequence
  sequence cmd_rd_s;
    i_rd && i_addr == cmd_irq_pkg::OFS_COMMAND;
  endsequence
  rd_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  rsvd_read_a: assert property ($past(i_rd) &&
    $past(i_addr) == cmd_irq_pkg::OFS_RESERVED |-> o_rdata == 8'h00)
    else $error("reserved register read not zero");
  cmd_read_a: assert property (cmd_rd_s |=>
    o_rdata[3:0] == $past(o_ctrl.command_code) && o_rdata[7:6] == 2'b00)
    else $error("command read does not show running code");
  rcv_off_a: assert property (cmd_wr_s |=>
    o_ctrl.receiver_analog_off == $past(i_wdata[5]))
    else $error("receiver off control not written");
  sleep_set_a: assert property (cmd_wr_s ##0 (i_wdata[4] &&
    o_ctrl.command_code != cmd_irq_pkg::CODE_RESTART) |=> o_ctrl.soft_sleep_request)
    else $error("sleep write did not enter sleep");
  sleep_block_a: assert property (cmd_wr_s ##0 (!o_ctrl.soft_sleep_request &&
    o_ctrl.command_code == cmd_irq_pkg::CODE_RESTART) |=> !o_ctrl.soft_sleep_request)
    else $error("sleep entered during restart");
  sleep_cause_a: assert property ($rose(o_ctrl.soft_sleep_request) |->
    $past(i_wr) && $past(i_addr) == cmd_irq_pkg::OFS_COMMAND)
    else $error("sleep without a command write");
  code_load_a: assert property (cmd_wr_s ##0 (i_wdata[3:0] != 4'h0) |=>
    o_ctrl.command_code == $past(i_wdata[3:0]) && o_ctrl.command_start)
    else $error("command code not started");
  start_cause_a: assert property (o_ctrl.command_start |->
    $past(i_wr) && $past(i_addr) == cmd_irq_pkg::OFS_COMMAND)
    else $error("start pulse without a command write");
  idle_write_a: assert property (cmd_wr_s ##0 (i_wdata[3:0] == 4'h0) |=>
    o_ctrl.command_code == cmd_irq_pkg::CODE_IDLE && !o_ctrl.command_start)
    else $error("host idle write misbehaved");
  pin_release_a: assert property (o_irq_oe_n |-> !o_irq_out)
    else $error("released interrupt pin still drives high");
endmodule // cmd_irq_monitor

bind command_and_interrupt_regs cmd_irq_monitor u_mon (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_evt(i_evt), .o_ctrl(o_ctrl), .i_irq_in(i_irq_in),
  .o_irq_out(o_irq_out), .o_irq_oe_n(o_irq_oe_n));

// ===== sim/command_and_interrupt_regs_tb.sv
// self-checking bench for the command and interrupt register group
// assumes a pulled-up interrupt wire and events from the bench
`timescale 1ns/1ps
module command_and_interrupt_regs_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [5:0] i_addr = 6'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  cmd_irq_pkg::event_in_t i_evt = '0;
  cmd_irq_pkg::event_in_t base = '0;
  cmd_irq_pkg::core_ctrl_t o_ctrl;
  logic o_irq_out;
  logic o_irq_oe_n;
  logic irq_line;
  logic [7:0] req;
  logic [7:0] rst_v [6] = '{8'h00, 8'h20, 8'h80, 8'h00, 8'h14, 8'h00};
  int fails = 0;
  int checks_done = 0;
  int r;
  always #5 i_clk_sys = ~i_clk_sys;
  command_and_interrupt_regs DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_evt(i_evt), .o_ctrl(o_ctrl), .i_irq_in(irq_line), .o_irq_out(o_irq_out),
    .o_irq_oe_n(o_irq_oe_n));
  irq_line_model u_line (.i_irq_out(o_irq_out), .i_irq_oe_n(o_irq_oe_n), .o_line(irq_line));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  // pin settles within three edges of any cause
  task automatic pin(input logic [1:0] e);
    repeat (3) @(posedge i_clk_sys);
    #1 chk({6'h00, o_irq_oe_n, irq_line}, {6'h00, e});
  endtask
  task automatic ev(input int k);
    cmd_irq_pkg::event_in_t e;
    e = base;
    case (k)
      0: e.tx_last_bit_sent = 1'b1;
      1: e.rx_stream_end = 1'b1;
      2: e.fifo_high_watermark = 1'b1;
      3: e.fifo_low_watermark = 1'b1;
      4: e.error_flag_register = 8'h01 << r[2:0];
      5: e.timer_count_zero = 1'b1;
      6: e.command_finished = 1'b1;
      7: e.checksum_data_done = 1'b1;
      8: e.wake_ready = 1'b1;
      default: base.card_side_serial_input = ~base.card_side_serial_input;
    endcase
    @(posedge i_clk_sys);
    i_evt <= e;
    @(posedge i_clk_sys);
    i_evt <= base;
  endtask
  function automatic logic [7:0] evbit(input int k);
    return 8'h40 >> (k + (k > 1));
  endfunction
  function automatic logic [7:0] mark(input logic [7:0] old, input logic [7:0] w);
    return w[7] ? (old | w) & 8'h7f : old & ~w;
  endfunction
  // wire level: flag xor invert; push-pull always drives
  function automatic logic [1:0] exp_pin(input logic f, input logic inv, input logic pp);
    return {~pp & (f ^ inv), f ^ inv};
  endfunction
  initial begin
    r = $urandom(97375);
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    for (int i = 0; i < 6; i++) rd(i[5:0], rst_v[i]); // reset values
    rd(6'h3f, 8'h00);
    pin(exp_pin(1'b0, 1'b1, 1'b0)); // floats after reset
    req = 8'h14;
    for (int i = 0; i < 10; i++) begin
      r = $urandom;
      wr(6'h04, r[7:0]);
      req = mark(req, r[7:0]);
      rd(6'h04, req); // mark and set
    end
    wr(6'h04, 8'h7f);
    for (int k = 0; k < 6; k++) begin
      ev(k);
      rd(6'h04, evbit(k)); // events latch
      wr(6'h04, 8'h7f);
      rd(6'h04, 8'h00); // software clear
    end
    base.rx_require_data = 1'b1;
    ev(1);
    rd(6'h04, 8'h00); // no data held
    base.fifo_has_data = 1'b1;
    ev(1);
    rd(6'h04, 8'h20); // data held
    wr(6'h04, 8'h7f);
    wr(6'h01, 8'h03);
    rd(6'h01, 8'h03); // code written
    ev(6);
    rd(6'h01, 8'h00); // back to idle
    rd(6'h04, 8'h10); // idle request
    wr(6'h04, 8'h7f);
    wr(6'h01, 8'h03);
    wr(6'h01, 8'h20);
    rd(6'h04, 8'h00); // host idle write
    rd(6'h01, 8'h20); // receiver off bit
    wr(6'h01, 8'h03);
    ev(7);
    ev(9);
    rd(6'h05, 8'h14); // aux requests
    ev(6);
    wr(6'h02, 8'h40);
    wr(6'h03, 8'h80);
    pin(exp_pin(1'b0, 1'b0, 1'b1)); // no enabled request pending
    ev(0);
    pin(exp_pin(1'b1, 1'b0, 1'b1)); // enabled request
    wr(6'h02, 8'hc0);
    pin(exp_pin(1'b1, 1'b1, 1'b1)); // inverted
    wr(6'h03, 8'h00);
    pin(exp_pin(1'b1, 1'b1, 1'b0)); // open drain low
    wr(6'h04, 8'h7f);
    pin(exp_pin(1'b0, 1'b1, 1'b0)); // released
    wr(6'h03, 8'hff);
    rd(6'h03, 8'h94); // reserved enables
    wr(6'h02, 8'h80);
    pin(exp_pin(1'b1, 1'b1, 1'b1)); // aux requests reach pin
    wr(6'h05, 8'h14);
    pin(exp_pin(1'b0, 1'b1, 1'b1)); // aux cleared
    wr(6'h01, 8'h10);
    wr(6'h01, 8'h00);
    rd(6'h01, 8'h10); // reads one while waking
    wr(6'h01, 8'h10);
    wr(6'h01, 8'h00);
    rd(6'h01, 8'h10); // sleep again during wake-up
    ev(8);
    rd(6'h01, 8'h00); // ready
    wr(6'h01, 8'h0f);
    wr(6'h01, 8'h1f);
    rd(6'h01, 8'h0f); // sleep refused
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    rd(6'h04, 8'h14); // second reset
    rd(6'h05, 8'h00); // no false card edge after reset
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fails++;
    end_sim();
  end
endmodule // command_and_interrupt_regs_tb
